// [logic/cwd_pkg.sv]
// constants and carriers for configuration word decode and protection
package cwd_pkg;
  localparam int        WORD_W        = 14;
  localparam int        ADDR_W        = 16;
  // word addresses on the nonvolatile path
  localparam logic [15:0] ADDR_REV    = 16'h8005;
  localparam logic [15:0] ADDR_PARTID = 16'h8006;
  localparam logic [15:0] ADDR_CFG2   = 16'h8008;
  localparam logic [15:0] ADDR_CFG3   = 16'h8009;
  localparam logic [15:0] ADDR_CFG4   = 16'h800A;
  localparam logic [15:0] ADDR_CFG5   = 16'h800B;
  // second word fields
  localparam int        B_DEBUG       = 13;
  localparam int        B_BRNLVL      = 9;
  localparam int        B_POWERUP_DELAY_SELECT       = 1;
  localparam int        B_RSTPIN      = 0;
  // fourth word fields
  localparam int        B_LVP         = 13;
  localparam int        B_WP_STORE    = 11;
  localparam int        B_WP_CFG      = 9;
  localparam int        B_WP_BOOT     = 8;
  localparam int        B_WP_APP      = 7;
  localparam int        B_STORE_EN_N  = 4;
  localparam int        B_BOOT_EN_N   = 3;
  localparam int        B_BOOT_SIZE   = 0;
  // fifth word field
  localparam int        B_CP_N        = 0;
  // protection bits that may only move from 1 to 0 outside a bulk erase or por
  localparam logic [13:0] CFG4_STICKY = 14'h0B98;
  localparam logic [13:0] CFG5_STICKY = 14'h0001;
  localparam logic [13:0] ERASED      = 14'h3FFF;
  // identification word layout
  localparam logic [1:0]  PARTID_TOP  = 2'h3;
  localparam logic [1:0]  REV_TOP     = 2'h2;
  // power-up timer codes and times
  localparam logic [1:0]  POWERUP_TIMER_64MS   = 2'h2;
  localparam logic [1:0]  POWERUP_TIMER_16MS   = 2'h1;
  localparam logic [1:0]  POWERUP_TIMER_1MS    = 2'h0;
  localparam logic [1:0]  POWERUP_TIMER_OFF    = 2'h3;
  localparam int        CLK_MHZ       = 50;
  localparam int        T_POWERUP_TIMER_64_US  = 64000;
  localparam int        T_POWERUP_TIMER_16_US  = 16000;
  localparam int        T_POWERUP_TIMER_1_US   = 1000;
  localparam int        CYC_POWERUP_TIMER_64   = T_POWERUP_TIMER_64_US * CLK_MHZ;
  localparam int        CYC_POWERUP_TIMER_16   = T_POWERUP_TIMER_16_US * CLK_MHZ;
  localparam int        CYC_POWERUP_TIMER_1    = T_POWERUP_TIMER_1_US * CLK_MHZ;
  localparam int        STORE_WORDS   = 128;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [13:0] wdata;
  } cwd_req_t;

  typedef struct packed {
    logic        wr_err;
    logic [13:0] rdata;
  } cwd_resp_t;
endpackage

// [logic/cwd_boot_map.sv]
// boot region end address with clamp to half of program memory
`timescale 1ns/10ps
`default_nettype none
module cwd_boot_map #(
  parameter int PFM_WORDS = 4096
) (
  // size code
  input  wire logic [2:0]  size_code,
  // last boot address
  output logic      [14:0] boot_end
);
  localparam logic [15:0] HALF_END = 16'(PFM_WORDS / 2 - 1);
  logic [15:0] raw_end;

  always_comb begin
    case (size_code)
      3'h7:    raw_end = 16'h01FF;
      3'h6:    raw_end = 16'h03FF;
      3'h5:    raw_end = 16'h07FF;
      3'h4:    raw_end = 16'h0FFF;
      3'h3:    raw_end = 16'h1FFF;
      default: raw_end = 16'h3FFF;
    endcase
    boot_end = (raw_end > HALF_END) ? HALF_END[14:0] : raw_end[14:0];
  end
endmodule // cwd_boot_map
`default_nettype wire

// [logic/cwd_powerup_timer_timer.sv]
// power-up delay counter
`timescale 1ns/10ps
`default_nettype none
module cwd_powerup_timer_timer #(
  parameter int CYC_64 = cwd_pkg::CYC_POWERUP_TIMER_64,
  parameter int CYC_16 = cwd_pkg::CYC_POWERUP_TIMER_16,
  parameter int CYC_1  = cwd_pkg::CYC_POWERUP_TIMER_1
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // start with selection
  input  wire logic       start,
  input  wire logic [1:0] sel,
  // delay elapsed
  output logic            done
);
  logic [23:0] cnt_ff;
  logic        run_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_ff <= 24'h000000;
      run_ff <= 1'b0;
      done   <= 1'b0;
    end else if (start) begin
      case (sel)
        cwd_pkg::POWERUP_TIMER_64MS: cnt_ff <= 24'(CYC_64 - 1);
        cwd_pkg::POWERUP_TIMER_16MS: cnt_ff <= 24'(CYC_16 - 1);
        cwd_pkg::POWERUP_TIMER_1MS:  cnt_ff <= 24'(CYC_1 - 1);
        default:            cnt_ff <= 24'h000000;
      endcase
      run_ff <= (sel != cwd_pkg::POWERUP_TIMER_OFF);
      done   <= (sel == cwd_pkg::POWERUP_TIMER_OFF);
    end else if (run_ff) begin
      if (cnt_ff == 24'h000000) begin
        run_ff <= 1'b0;
        done   <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff - 24'h000001;
      end
    end
  end
endmodule // cwd_powerup_timer_timer
`default_nettype wire

// [logic/cwd_config_decode.sv]
// configuration word store, protection and decode
// Operation
// - code 01 gives 16 ms, 00 gives 1 ms
// - code 11 disables timer, 10 gives 64 ms
// - without low-voltage mode, enable bit picks reset pin
// - low-voltage mode forces pin to master reset
// - refuse clearing low-voltage bit over that interface
// - brown-out threshold follows level select bit
// - cleared bit protects enabled storage region
// - cleared bit protects configuration words
// - cleared bit protects enabled boot region
// - cleared bit protects application region
// - protection cleared only by bulk erase; the code also clears it on por
// - storage region enable is active low
// - storage region is last 128 words, no execution
// - boot enable active low, disabled ignores size
// - size code maps to last boot address
// - size changes only while boot disabled
// - boot region clamped to half program memory
// - cleared code-protect bit protects program flash
// - code protection immediate, removed by bulk erase
// - identification word read-only, fixed top bits
// - revision word read-only, fixed top bits
// - third word reserved, no settings
`timescale 1ns/10ps
`default_nettype none
module cwd_config_decode #(
  parameter int          PFM_WORDS   = 4096,
  parameter logic [11:0] PART_ID     = 12'hA5C, // arbitrary value
  parameter logic [5:0]  MAJOR_REV   = 6'h01,   // arbitrary value
  parameter logic [5:0]  MINOR_REV   = 6'h02,   // arbitrary value
  parameter int          CYC_64      = cwd_pkg::CYC_POWERUP_TIMER_64,
  parameter int          CYC_16      = cwd_pkg::CYC_POWERUP_TIMER_16,
  parameter int          CYC_1       = cwd_pkg::CYC_POWERUP_TIMER_1
) (
  // clock and resets
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              por,
  // nonvolatile access path
  input  wire logic              nvm_req,
  input  wire cwd_pkg::cwd_req_t nvm_cmd,
  input  wire logic              bulk_erase,
  input  wire logic              lvp_if_active,
  output logic                   nvm_ack,
  output cwd_pkg::cwd_resp_t     nvm_resp,
  output logic                   pfm_wr_grant,
  // decoded settings
  output logic                   powerup_done,
  output logic                   reset_pin_is_master,
  output logic                   low_voltage_program_en,
  output logic                   brownout_level_high,
  output logic                   debug_en_n,
  output logic                   storage_region_en,
  output logic [14:0]            storage_region_start,
  output logic                   boot_region_en,
  output logic [14:0]            boot_region_end,
  output logic [3:0]             wprot_active,
  output logic                   code_protect_active
);
  // nonvolatile store, kept across srst
  logic [13:0] cfg2_ff;
  logic [13:0] cfg4_ff;
  logic [13:0] cfg5_ff;
  // reset-time latches
  logic [13:0] lat2_ff;
  logic [13:0] lat4_ff;
  logic [13:0] lat5_ff;
  logic        load_pend_ff;
  logic        timer_start_ff;
  logic [13:0] nxt_cfg4;
  logic [13:0] nxt_cfg5;
  logic [14:0] pfm_addr;
  logic        is_pfm;
  logic        in_store;
  logic        in_boot;
  logic        pfm_blocked;
  logic        cfg_wr_ok;
  logic        lvp_refused;
  logic [14:0] boot_end_w;
  logic        wr_cfg2;
  logic        wr_cfg4;
  logic        wr_cfg5;
  logic        wr_err;
  logic [13:0] rd_word;

  localparam logic [14:0] STORE_START = 15'(PFM_WORDS - cwd_pkg::STORE_WORDS);

  // address decode against the live store, so new protection acts at once
  assign pfm_addr  = nvm_cmd.addr[14:0] & 15'(PFM_WORDS - 1);
  assign is_pfm    = !nvm_cmd.addr[15];
  assign in_store  = !cfg4_ff[cwd_pkg::B_STORE_EN_N] && pfm_addr >= STORE_START;
  assign in_boot   = !cfg4_ff[cwd_pkg::B_BOOT_EN_N] && pfm_addr <= boot_end_w;

  always_comb begin
    if (in_store) begin
      pfm_blocked = !cfg4_ff[cwd_pkg::B_WP_STORE];
    end else if (in_boot) begin
      pfm_blocked = !cfg4_ff[cwd_pkg::B_WP_BOOT];
    end else begin
      pfm_blocked = !cfg4_ff[cwd_pkg::B_WP_APP];
    end
  end

  assign cfg_wr_ok   = cfg4_ff[cwd_pkg::B_WP_CFG];
  assign wr_cfg2     = nvm_req && nvm_cmd.we && nvm_cmd.addr == cwd_pkg::ADDR_CFG2 && cfg_wr_ok;
  assign wr_cfg4     = nvm_req && nvm_cmd.we && nvm_cmd.addr == cwd_pkg::ADDR_CFG4 && cfg_wr_ok;
  assign wr_cfg5     = nvm_req && nvm_cmd.we && nvm_cmd.addr == cwd_pkg::ADDR_CFG5 && cfg_wr_ok;
  assign lvp_refused = lvp_if_active && !nvm_cmd.wdata[cwd_pkg::B_LVP]
                       && cfg4_ff[cwd_pkg::B_LVP];

  always_comb begin
    // protection bits only fall; bulk erase or por is the way back up
    nxt_cfg4 = (cfg4_ff & cwd_pkg::CFG4_STICKY & nvm_cmd.wdata)
               | (nvm_cmd.wdata & ~cwd_pkg::CFG4_STICKY);
    if (!cfg4_ff[cwd_pkg::B_BOOT_EN_N]) begin
      nxt_cfg4[2:0] = cfg4_ff[2:0];
    end
    if (lvp_refused) begin
      nxt_cfg4[cwd_pkg::B_LVP] = 1'b1;
    end
    nxt_cfg5 = (cfg5_ff & cwd_pkg::CFG5_STICKY & nvm_cmd.wdata)
               | (nvm_cmd.wdata & ~cwd_pkg::CFG5_STICKY);
  end

  always_comb begin
    wr_err = 1'b0;
    if (nvm_req && nvm_cmd.we) begin
      if (is_pfm) begin
        wr_err = pfm_blocked;
      end else begin
        case (nvm_cmd.addr)
          cwd_pkg::ADDR_REV, cwd_pkg::ADDR_PARTID: wr_err = 1'b1;
          cwd_pkg::ADDR_CFG2, cwd_pkg::ADDR_CFG5:  wr_err = !cfg_wr_ok;
          cwd_pkg::ADDR_CFG4:  wr_err = !cfg_wr_ok || lvp_refused;
          default:             wr_err = 1'b0;
        endcase
      end
    end
  end

  always_comb begin
    case (nvm_cmd.addr)
      cwd_pkg::ADDR_PARTID: rd_word = {cwd_pkg::PARTID_TOP, PART_ID};
      cwd_pkg::ADDR_REV:    rd_word = {cwd_pkg::REV_TOP, MAJOR_REV, MINOR_REV};
      cwd_pkg::ADDR_CFG2:   rd_word = cfg2_ff;
      cwd_pkg::ADDR_CFG4:   rd_word = cfg4_ff;
      cwd_pkg::ADDR_CFG5:   rd_word = cfg5_ff;
      default:              rd_word = 14'h0000;
    endcase
  end

  // nonvolatile store; third word holds nothing
  always_ff @(posedge sys_clk) begin
    if (por || bulk_erase) begin
      cfg2_ff <= cwd_pkg::ERASED;
      cfg4_ff <= cwd_pkg::ERASED;
      cfg5_ff <= cwd_pkg::ERASED;
    end else begin
      if (wr_cfg2) begin
        cfg2_ff <= nvm_cmd.wdata;
      end
      if (wr_cfg4) begin
        cfg4_ff <= nxt_cfg4;
      end
      if (wr_cfg5) begin
        cfg5_ff <= nxt_cfg5;
      end
    end
  end

  // access answer, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (srst || por) begin
      nvm_ack      <= 1'b0;
      nvm_resp     <= '0;
      pfm_wr_grant <= 1'b0;
    end else begin
      nvm_ack         <= nvm_req;
      nvm_resp.rdata  <= (nvm_req && !nvm_cmd.we) ? rd_word : 14'h0000;
      nvm_resp.wr_err <= wr_err;
      pfm_wr_grant    <= nvm_req && nvm_cmd.we && is_pfm && !pfm_blocked;
    end
  end

  // latch the words on the first edge out of reset
  always_ff @(posedge sys_clk) begin
    if (srst || por) begin
      load_pend_ff   <= 1'b1;
      timer_start_ff <= 1'b0;
      lat2_ff        <= cwd_pkg::ERASED;
      lat4_ff        <= cwd_pkg::ERASED;
      lat5_ff        <= cwd_pkg::ERASED;
    end else begin
      timer_start_ff <= load_pend_ff;
      if (load_pend_ff) begin
        load_pend_ff <= 1'b0;
        lat2_ff      <= cfg2_ff;
        lat4_ff      <= cfg4_ff;
        lat5_ff      <= cfg5_ff;
      end
    end
  end

  // decoded settings come from the latches; boot_region_end takes its size from the live store
  always_ff @(posedge sys_clk) begin
    if (srst || por) begin
      reset_pin_is_master    <= 1'b1;
      low_voltage_program_en <= 1'b1;
      brownout_level_high    <= 1'b1;
      debug_en_n             <= 1'b1;
    end else begin
      reset_pin_is_master    <= lat4_ff[cwd_pkg::B_LVP]
                                | lat2_ff[cwd_pkg::B_RSTPIN];
      low_voltage_program_en <= lat4_ff[cwd_pkg::B_LVP];
      brownout_level_high    <= lat2_ff[cwd_pkg::B_BRNLVL];
      debug_en_n             <= lat2_ff[cwd_pkg::B_DEBUG];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || por) begin
      storage_region_en    <= 1'b0;
      storage_region_start <= 15'h0000;
      boot_region_en       <= 1'b0;
      boot_region_end      <= 15'h0000;
      wprot_active         <= 4'h0;
    end else begin
      storage_region_en    <= !lat4_ff[cwd_pkg::B_STORE_EN_N];
      storage_region_start <= STORE_START;
      boot_region_en       <= !lat4_ff[cwd_pkg::B_BOOT_EN_N];
      boot_region_end      <= lat4_ff[cwd_pkg::B_BOOT_EN_N] ? 15'h0000 : boot_end_w;
      wprot_active         <= {!lat4_ff[cwd_pkg::B_WP_STORE] && !lat4_ff[cwd_pkg::B_STORE_EN_N],
                               !lat4_ff[cwd_pkg::B_WP_CFG],
                               !lat4_ff[cwd_pkg::B_WP_BOOT] && !lat4_ff[cwd_pkg::B_BOOT_EN_N],
                               !lat4_ff[cwd_pkg::B_WP_APP]};
    end
  end

  // code protect follows the store, not the latch: it must bite at once
  always_ff @(posedge sys_clk) begin
    if (por) begin
      code_protect_active <= 1'b0;
    end else begin
      code_protect_active <= !cfg5_ff[cwd_pkg::B_CP_N];
    end
  end

  // boot size read from the live store so protection decode stays current
  cwd_boot_map #(
    .PFM_WORDS (PFM_WORDS)
  ) u_boot_map (
    .size_code (cfg4_ff[2:0]),
    .boot_end  (boot_end_w)
  );

  cwd_powerup_timer_timer #(
    .CYC_64 (CYC_64),
    .CYC_16 (CYC_16),
    .CYC_1  (CYC_1)
  ) u_powerup_timer (
    .sys_clk (sys_clk),
    .srst    (srst || por),
    .start   (timer_start_ff),
    .sel     (lat2_ff[2:1]),
    .done    (powerup_done)
  );

  // checks
  property p_ack_next;
    @(posedge sys_clk) disable iff (srst || por)
    nvm_req |=> nvm_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no answer after request");

  property p_pin_decode;
    @(posedge sys_clk) disable iff (srst || por)
    !load_pend_ff |=> reset_pin_is_master == ($past(lat4_ff[13]) | $past(lat2_ff[0]));
  endproperty
  a_pin_decode: assert property (p_pin_decode) else $error("reset pin decode wrong");

  property p_lvp_refuse;
    @(posedge sys_clk) disable iff (srst || por || bulk_erase)
    nvm_req && nvm_cmd.we && nvm_cmd.addr == cwd_pkg::ADDR_CFG4 && lvp_refused && cfg_wr_ok
      |=> cfg4_ff[13] && nvm_resp.wr_err;
  endproperty
  a_lvp_refuse: assert property (p_lvp_refuse) else $error("low-voltage bit cleared");

  property p_cfg_locked;
    @(posedge sys_clk) disable iff (srst || por || bulk_erase)
    !cfg4_ff[9] |=> $stable(cfg4_ff) && $stable(cfg5_ff) && $stable(cfg2_ff);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("locked word changed");

  property p_app_sticky;
    @(posedge sys_clk) disable iff (srst || por || bulk_erase)
    !cfg4_ff[7] |=> !cfg4_ff[7];
  endproperty
  a_app_sticky: assert property (p_app_sticky) else $error("protection released");

  property p_size_lock;
    @(posedge sys_clk) disable iff (srst || por || bulk_erase)
    !cfg4_ff[3] |=> $stable(cfg4_ff[2:0]);
  endproperty
  a_size_lock: assert property (p_size_lock) else $error("boot size changed");

  property p_cp_now;
    @(posedge sys_clk) disable iff (por || bulk_erase)
    wr_cfg5 && !nvm_cmd.wdata[0] |=> ##1 code_protect_active;
  endproperty
  a_cp_now: assert property (p_cp_now) else $error("code protect late");

  property p_id_read;
    @(posedge sys_clk) disable iff (srst || por)
    nvm_req && !nvm_cmd.we && nvm_cmd.addr == cwd_pkg::ADDR_PARTID
      |=> nvm_resp.rdata[13:12] == 2'h3 && nvm_resp.rdata[11:0] == PART_ID;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identification read wrong");

  property p_boot_clamp;
    @(posedge sys_clk) disable iff (srst || por)
    boot_region_end <= 15'(PFM_WORDS / 2 - 1);
  endproperty
  a_boot_clamp: assert property (p_boot_clamp) else $error("boot region too large");

  property p_app_block;
    @(posedge sys_clk) disable iff (srst || por)
    nvm_req && nvm_cmd.we && is_pfm && !in_store && !in_boot && !cfg4_ff[7]
      |=> nvm_resp.wr_err && !pfm_wr_grant;
  endproperty
  a_app_block: assert property (p_app_block) else $error("protected write granted");

  c_grant: cover property (@(posedge sys_clk) pfm_wr_grant);
  c_cp_set: cover property (@(posedge sys_clk) $rose(code_protect_active));
  c_erase: cover property (@(posedge sys_clk) bulk_erase && !cfg4_ff[7]);
endmodule // cwd_config_decode
`default_nettype wire

// [verif/cwd_prog_model.sv]
// programmer model on the nonvolatile access path
`timescale 1ns/10ps
`default_nettype none
module cwd_prog_model (
  // clock
  input  wire logic               sys_clk,
  // request side
  output var  logic               nvm_req,
  output var  cwd_pkg::cwd_req_t  nvm_cmd,
  // answer side
  input  wire logic               nvm_ack,
  input  wire cwd_pkg::cwd_resp_t nvm_resp,
  input  wire logic               pfm_wr_grant
);
  initial begin
    nvm_req = 1'b0;
    nvm_cmd = '0;
  end
  // one access per call; lines scrambled once released
  task automatic access(input logic we, input logic [15:0] a, input logic [13:0] d,
                        output cwd_pkg::cwd_resp_t r, output logic g, output logic ak);
    @(posedge sys_clk) #1;
    nvm_req = 1'b1;
    nvm_cmd = '{we, a, d};
    @(posedge sys_clk) #1;
    nvm_req = 1'b0;
    nvm_cmd = ~nvm_cmd;
    r = nvm_resp;
    g = pfm_wr_grant;
    ak = nvm_ack;
  endtask
  // debugger bit always left at one
  function automatic logic [13:0] cfg2_word(input logic [1:0] dly, input logic pin,
                                            input logic lvl);
    cfg2_word = {1'b1, 3'h7, lvl, 6'h3F, dly, pin};
  endfunction
endmodule // cwd_prog_model
`default_nettype wire

// [verif/config_word_decode_protection_bench.sv]
// self-checking bench for configuration decode and protection
`timescale 1ns/10ps
`default_nettype none
module config_word_decode_protection_bench;
  localparam logic [11:0] PID = 12'h3C9; // arbitrary value
  localparam logic [5:0]  MAJ = 6'h05;   // arbitrary value
  localparam logic [5:0]  MIN = 6'h11;   // arbitrary value
  logic sys_clk, srst, por, bulk_erase, lvp_if_active, nvm_req, nvm_ack, pfm_wr_grant;
  logic powerup_done, reset_pin_is_master, low_voltage_program_en, brownout_level_high;
  logic debug_en_n, storage_region_en, boot_region_en, code_protect_active, gnt;
  logic [14:0] storage_region_start, boot_region_end;
  logic [3:0] wprot_active;
  cwd_pkg::cwd_req_t  nvm_cmd;
  cwd_pkg::cwd_resp_t nvm_resp, rsp;
  int n_mismatch = 0;
  int n_tests = 0;

  cwd_config_decode #(.PFM_WORDS(4096), .PART_ID(PID), .MAJOR_REV(MAJ), .MINOR_REV(MIN),
    .CYC_64(40), .CYC_16(20), .CYC_1(10)) dut (
    .sys_clk(sys_clk), .srst(srst), .por(por), .nvm_req(nvm_req), .nvm_cmd(nvm_cmd),
    .bulk_erase(bulk_erase), .lvp_if_active(lvp_if_active), .nvm_ack(nvm_ack),
    .nvm_resp(nvm_resp), .pfm_wr_grant(pfm_wr_grant), .powerup_done(powerup_done),
    .reset_pin_is_master(reset_pin_is_master), .low_voltage_program_en(low_voltage_program_en),
    .brownout_level_high(brownout_level_high), .debug_en_n(debug_en_n),
    .storage_region_en(storage_region_en), .storage_region_start(storage_region_start),
    .boot_region_en(boot_region_en), .boot_region_end(boot_region_end),
    .wprot_active(wprot_active), .code_protect_active(code_protect_active));

  cwd_prog_model prog (.sys_clk(sys_clk), .nvm_req(nvm_req), .nvm_cmd(nvm_cmd),
    .nvm_ack(nvm_ack), .nvm_resp(nvm_resp), .pfm_wr_grant(pfm_wr_grant));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic we, input logic [15:0] a, input logic [13:0] d);
    logic ak;
    prog.access(we, a, d, rsp, gnt, ak);
    chk_bit("ack", 1'b1, ak);
  endtask
  task automatic rd(input logic [15:0] a, input logic [13:0] e);
    acc(1'b0, a, 14'h0000);
    chk_val("read word", {2'h0, e}, {2'h0, rsp.rdata});
  endtask
  // blk: write expected to be refused
  task automatic wr(input logic [15:0] a, input logic [13:0] d, input logic blk);
    acc(1'b1, a, d);
    chk_bit("wr_err", blk, rsp.wr_err);
    if (a[15] == 1'b0)
      chk_bit("grant", ~blk, gnt);
  endtask
  task automatic rst_pulse(input logic full);
    @(posedge sys_clk) #1;
    srst = 1'b1;
    por = full;
    repeat (2) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    por = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic erase();
    @(posedge sys_clk) #1;
    bulk_erase = 1'b1;
    @(posedge sys_clk) #1;
    bulk_erase = 1'b0;
    @(posedge sys_clk) #1;
  endtask

  task automatic t_ident();
    rd(cwd_pkg::ADDR_PARTID, {2'h3, PID});
    wr(cwd_pkg::ADDR_PARTID, 14'h0000, 1'b1);
    rd(cwd_pkg::ADDR_PARTID, {2'h3, PID});
    wr(cwd_pkg::ADDR_REV, 14'h0000, 1'b1);
    rd(cwd_pkg::ADDR_REV, {2'h2, MAJ, MIN});
    wr(cwd_pkg::ADDR_CFG3, 14'h0000, 1'b0);
    rd(cwd_pkg::ADDR_CFG3, 14'h0000);
    rd(16'h8010, 14'h0000);
  endtask
  task automatic t_powerup_timer();
    int lim[4] = '{10, 20, 40, 0};
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(cwd_pkg::ADDR_CFG2, prog.cfg2_word(2'(c), c[0], c[1]), 1'b0);
      @(posedge sys_clk) #1;
      srst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      n = 0;
      while (powerup_done !== 1'b1 && n < 100) begin
        @(posedge sys_clk) #1;
        n++;
      end
      chk_bit("powerup_timer low", 1'b1, n >= lim[c]);
      chk_bit("powerup_timer high", 1'b1, n <= lim[c] + 5);
      chk_bit("pin master", 1'b1, reset_pin_is_master);
      chk_bit("brown level", c[1], brownout_level_high);
      chk_bit("debug", 1'b1, debug_en_n);
    end
  endtask
  task automatic t_lvp();
    lvp_if_active = 1'b1;
    wr(cwd_pkg::ADDR_CFG4, 14'h1FFF, 1'b1);
    rd(cwd_pkg::ADDR_CFG4, 14'h3FFF);
    lvp_if_active = 1'b0;
    wr(cwd_pkg::ADDR_CFG4, 14'h1FFF, 1'b0);
    // lower level bit: lower threshold, brownout_level_high reads 0
    wr(cwd_pkg::ADDR_CFG2, prog.cfg2_word(2'h3, 1'b0, 1'b0), 1'b0);
    chk_bit("still latched", 1'b1, reset_pin_is_master);
    rst_pulse(1'b0);
    chk_bit("pin port", 1'b0, reset_pin_is_master);
    chk_bit("lvp off", 1'b0, low_voltage_program_en);
    chk_bit("brown level", 1'b0, brownout_level_high);
    wr(cwd_pkg::ADDR_CFG2, prog.cfg2_word(2'h3, 1'b1, 1'b1), 1'b0);
    rst_pulse(1'b0);
    chk_bit("pin master", 1'b1, reset_pin_is_master);
  endtask
  task automatic t_boot();
    logic [14:0] last[8] = '{15'h07FF, 15'h07FF, 15'h07FF, 15'h07FF, 15'h07FF, 15'h07FF,
                             15'h03FF, 15'h01FF};
    rst_pulse(1'b1);
    wr(cwd_pkg::ADDR_CFG4, 14'h3FFD, 1'b0);
    rd(cwd_pkg::ADDR_CFG4, 14'h3FFD);
    rst_pulse(1'b0);
    chk_bit("boot off", 1'b0, boot_region_en);
    chk_val("boot end off", 16'h0000, {1'b0, boot_region_end});
    for (int c = 0; c < 8; c++) begin
      rst_pulse(1'b1);
      wr(cwd_pkg::ADDR_CFG4, 14'h3FF0 | 14'(c), 1'b0);
      acc(1'b1, cwd_pkg::ADDR_CFG4, 14'h3FF0 | 14'(7 - c));
      rd(cwd_pkg::ADDR_CFG4, 14'h3FF0 | 14'(c));
      rst_pulse(1'b0);
      chk_bit("boot on", 1'b1, boot_region_en);
      chk_val("boot end", {1'b0, last[c]}, {1'b0, boot_region_end});
    end
  endtask
  task automatic t_regions();
    rst_pulse(1'b1);
    wr(cwd_pkg::ADDR_CFG4, 14'h36E7, 1'b0);
    rst_pulse(1'b0);
    chk_bit("store on", 1'b1, storage_region_en);
    chk_val("store start", 16'h0F80, {1'b0, storage_region_start});
    chk_val("wprot", 16'h000A, {12'h000, wprot_active});
    wr(16'h0100, 14'h0000, 1'b1);
    wr(16'h0300, 14'h0000, 1'b0);
    wr(16'h0F80, 14'h0000, 1'b1);
    wr(16'h0F7F, 14'h0000, 1'b0);
    wr(cwd_pkg::ADDR_CFG4, 14'h3667, 1'b0);
    wr(16'h0300, 14'h0000, 1'b1);
    acc(1'b1, cwd_pkg::ADDR_CFG4, 14'h3FFF);
    rd(cwd_pkg::ADDR_CFG4, 14'h3667);
    erase();
    rd(cwd_pkg::ADDR_CFG4, 14'h3FFF);
    wr(cwd_pkg::ADDR_CFG4, 14'h37FF, 1'b0);
    wr(16'h0F80, 14'h0000, 1'b0);
    erase();
    wr(cwd_pkg::ADDR_CFG4, 14'h3DFF, 1'b0);
    wr(cwd_pkg::ADDR_CFG2, 14'h0000, 1'b1);
    rd(cwd_pkg::ADDR_CFG2, 14'h3FFF);
    erase();
    wr(cwd_pkg::ADDR_CFG2, 14'h3FFE, 1'b0);
  endtask
  // protection word goes last, it bites at once
  task automatic t_code_prot();
    chk_bit("cp idle", 1'b0, code_protect_active);
    wr(cwd_pkg::ADDR_CFG5, 14'h3FFE, 1'b0);
    @(posedge sys_clk) #1;
    chk_bit("cp on", 1'b1, code_protect_active);
    acc(1'b1, cwd_pkg::ADDR_CFG5, 14'h3FFF);
    rd(cwd_pkg::ADDR_CFG5, 14'h3FFE);
    rst_pulse(1'b0);
    chk_bit("cp kept", 1'b1, code_protect_active);
    erase();
    chk_bit("cp erased", 1'b0, code_protect_active);
  endtask

  initial begin
    srst = 1'b1;
    por = 1'b1;
    bulk_erase = 1'b0;
    lvp_if_active = 1'b0;
    rst_pulse(1'b1);
    t_ident();
    t_powerup_timer();
    t_lvp();
    t_boot();
    t_regions();
    t_code_prot();
    final_report();
  end
  // whole run is a few hundred cycles
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule // config_word_decode_protection_bench
`default_nettype wire
